// file: hw/scan_defines.svh
// constants of the boundary-scan instruction logic
`ifndef SCAN_DEFINES_SVH
`define SCAN_DEFINES_SVH

// ----------------------------------------
// instruction codes
// ----------------------------------------
`define IR_WIDTH 3
`define IR_EXTEST 3'h0
`define IR_IDREAD 3'h1
`define IR_SAMPLE_Z 3'h2
`define IR_PRELOAD 3'h4
`define IR_BYPASS 3'h7
`define IR_RESET_VAL 3'h1
`define IR_CAPTURE_VAL 3'h1

// ----------------------------------------
// boundary chain layout
// ----------------------------------------
`define DQ_WIDTH 18
`define BSR_LEN 49
`define BSR_DQ_LSB 0
`define BSR_CQ_BIT 18
`define BSR_CQN_BIT 19
`define BSR_MISC_LSB 20
`define BSR_MISC_WIDTH 28
`define BSR_CTRL_BIT 48
`define ID_WIDTH 32

`endif

// file: hw/scan_pkg.sv
// types shared by the boundary-scan instruction logic
package scan_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_t;

  typedef enum logic [1:0] {
    PAD_SRAM, PAD_UPDATE_ALL, PAD_UPDATE_CQ, PAD_HIGHZ
  } pad_mode_t;

  // echo clocks and data of one output word
  typedef struct packed {
    logic cq;
    logic cq_n;
    logic [17:0] dq;
  } out_word_t;

  // what the test clock domain hands to the pad logic
  typedef struct packed {
    pad_mode_t mode;
    out_word_t upd;
  } pad_xfer_t;

endpackage

// file: hw/bit_sync.sv
// two flip-flop synchroniser for levels
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic clk,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end

endmodule // bit_sync

// file: hw/scan_instr_logic.sv
// boundary-scan instruction logic with pad steering
`timescale 1ns/100ps
`include "scan_defines.svh"
module scan_instr_logic
  import scan_pkg::*;
#(
  parameter logic [`ID_WIDTH-1:0] ID_VALUE = 32'h0000_0001 // arbitrary value
) (
  // system clock and reset
  input wire logic clock,
  input wire logic srst,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // memory side, system clock domain
  input wire out_word_t sram_out,
  input wire logic sram_out_oe,
  input wire logic sram_read,
  // pad levels
  input wire out_word_t pad_in,
  input wire logic [`BSR_MISC_WIDTH-1:0] misc_pad_in,
  // pad drive
  output out_word_t pad_out,
  output logic dq_oe,
  output logic echo_clock_oe,
  output logic test_highz
);

  // ----------------------------------------
  // crossings into the test clock domain
  // ----------------------------------------
  logic rst_t;
  out_word_t pad_s, sram_s;
  logic read_s;
  logic [`BSR_MISC_WIDTH-1:0] misc_s;

  bit_sync #(.WIDTH(1)) u_rst_sync (.clk(tck), .d(srst), .q(rst_t));
  bit_sync #(.WIDTH($bits(out_word_t))) u_pad_sync (.clk(tck), .d(pad_in), .q(pad_s));
  bit_sync #(.WIDTH($bits(out_word_t))) u_int_sync (.clk(tck), .d(sram_out), .q(sram_s));
  bit_sync #(.WIDTH(1)) u_read_sync (.clk(tck), .d(sram_read), .q(read_s));
  bit_sync #(.WIDTH(`BSR_MISC_WIDTH)) u_misc_sync (.clk(tck), .d(misc_pad_in), .q(misc_s));

  // ----------------------------------------
  // controller
  // ----------------------------------------
  tap_state_t tap_q, tap_d;

  always_comb begin
    tap_d = tap_q;
    unique case (tap_q)
      TEST_LOGIC_RESET: tap_d = tms ? TEST_LOGIC_RESET : RUN_IDLE;
      RUN_IDLE: tap_d = tms ? SELECT_DR : RUN_IDLE;
      SELECT_DR: tap_d = tms ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: tap_d = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: tap_d = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: tap_d = tms ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: tap_d = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: tap_d = tms ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: tap_d = tms ? SELECT_DR : RUN_IDLE;
      SELECT_IR: tap_d = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: tap_d = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: tap_d = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: tap_d = tms ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: tap_d = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: tap_d = tms ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: tap_d = tms ? SELECT_DR : RUN_IDLE;
    endcase
    if (rst_t) begin
      tap_d = TEST_LOGIC_RESET;
    end
  end

  always_ff @(posedge tck) begin
    tap_q <= tap_d;
  end

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  logic [`IR_WIDTH-1:0] ir_q, ir_d, ir_sh_q, ir_sh_d;

  always_comb begin
    ir_d = ir_q;
    ir_sh_d = ir_sh_q;
    if (rst_t || tap_q == TEST_LOGIC_RESET) begin
      ir_d = `IR_RESET_VAL;
    end else if (tap_q == CAPTURE_IR) begin
      ir_sh_d = `IR_CAPTURE_VAL;
    end else if (tap_q == SHIFT_IR) begin
      ir_sh_d = {tdi, ir_sh_q[`IR_WIDTH-1:1]};
    end else if (tap_q == UPDATE_IR) begin
      ir_d = ir_sh_q;
    end
  end

  always_ff @(posedge tck) begin
    ir_q <= ir_d;
    ir_sh_q <= ir_sh_d;
  end

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  logic is_extest, is_idread, is_sample_z, is_preload, use_bsr;

  // reserved codes fall through to bypass behaviour
  assign is_extest = (ir_q == `IR_EXTEST);
  assign is_idread = (ir_q == `IR_IDREAD);
  assign is_sample_z = (ir_q == `IR_SAMPLE_Z);
  assign is_preload = (ir_q == `IR_PRELOAD);
  assign use_bsr = is_extest | is_sample_z | is_preload;

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  logic [`BSR_LEN-1:0] bsr_q, bsr_d;
  out_word_t upd_q, upd_d;
  logic ctrl_q, ctrl_d;
  logic [`ID_WIDTH-1:0] id_q, id_d;
  logic byp_q, byp_d;
  out_word_t cap;

  // capture source per instruction and memory state
  always_comb begin
    cap = pad_s;
    if (is_preload) begin
      cap.cq = sram_s.cq;
      cap.cq_n = sram_s.cq_n;
      cap.dq = read_s ? sram_s.dq : pad_s.dq;
    end
  end

  always_comb begin
    bsr_d = bsr_q;
    upd_d = upd_q;
    ctrl_d = ctrl_q;
    id_d = id_q;
    byp_d = byp_q;
    if (rst_t) begin
      upd_d = '0;
      ctrl_d = 1'b0;
    end else if (tap_q == CAPTURE_DR) begin
      bsr_d[`BSR_DQ_LSB +: `DQ_WIDTH] = cap.dq;
      bsr_d[`BSR_CQ_BIT] = cap.cq;
      bsr_d[`BSR_CQN_BIT] = cap.cq_n;
      bsr_d[`BSR_MISC_LSB +: `BSR_MISC_WIDTH] = misc_s;
      bsr_d[`BSR_CTRL_BIT] = ctrl_q;
      id_d = ID_VALUE;
      byp_d = 1'b0;
    end else if (tap_q == SHIFT_DR) begin
      if (use_bsr) begin
        bsr_d = {tdi, bsr_q[`BSR_LEN-1:1]};
      end else if (is_idread) begin
        id_d = {tdi, id_q[`ID_WIDTH-1:1]};
      end else begin
        byp_d = tdi;
      end
    end else if (tap_q == UPDATE_DR && (is_extest || is_preload)) begin
      upd_d.dq = bsr_q[`BSR_DQ_LSB +: `DQ_WIDTH];
      upd_d.cq = bsr_q[`BSR_CQ_BIT];
      upd_d.cq_n = bsr_q[`BSR_CQN_BIT];
      ctrl_d = bsr_q[`BSR_CTRL_BIT];
    end
  end

  always_ff @(posedge tck) begin
    bsr_q <= bsr_d;
    upd_q <= upd_d;
    ctrl_q <= ctrl_d;
    id_q <= id_d;
    byp_q <= byp_d;
  end

  // ----------------------------------------
  // serial output, changes on falling edge
  // ----------------------------------------
  logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;

  always_comb begin
    tdo_d = tdo_q;
    tdo_oe_d = 1'b0;
    if (rst_t) begin
      tdo_d = 1'b0;
    end else if (tap_q == SHIFT_IR) begin
      tdo_d = ir_sh_q[0];
      tdo_oe_d = 1'b1;
    end else if (tap_q == SHIFT_DR) begin
      tdo_oe_d = 1'b1;
      if (use_bsr) begin
        tdo_d = bsr_q[0];
      end else if (is_idread) begin
        tdo_d = id_q[0];
      end else begin
        tdo_d = byp_q;
      end
    end
  end

  always_ff @(negedge tck) begin
    tdo_q <= tdo_d;
    tdo_oe_q <= tdo_oe_d;
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // ----------------------------------------
  // pad mode and hand-over to system clock
  // ----------------------------------------
  pad_xfer_t xfer_q, xfer_d;
  logic tog_q, tog_d;
  pad_mode_t mode_t;

  always_comb begin
    if (is_sample_z) begin
      mode_t = PAD_HIGHZ;
    end else if (is_extest) begin
      mode_t = ctrl_q ? PAD_UPDATE_ALL : PAD_UPDATE_CQ;
    end else begin
      mode_t = PAD_SRAM;
    end
  end

  always_comb begin
    xfer_d = xfer_q;
    tog_d = tog_q;
    if (rst_t) begin
      xfer_d = '{mode: PAD_SRAM, upd: '0};
      tog_d = 1'b0;
    end else if (xfer_q != pad_xfer_t'{mode: mode_t, upd: upd_q}) begin
      xfer_d = '{mode: mode_t, upd: upd_q};
      tog_d = ~tog_q;
    end
  end

  always_ff @(posedge tck) begin
    xfer_q <= xfer_d;
    tog_q <= tog_d;
  end

  logic tog_s;
  bit_sync #(.WIDTH(1)) u_tog_sync (.clk(clock), .d(tog_q), .q(tog_s));

  // ----------------------------------------
  // pad drive, system clock domain
  // ----------------------------------------
  logic seen_q, seen_d;
  pad_xfer_t held_q, held_d;
  out_word_t pad_q, pad_d;
  logic dq_oe_q, dq_oe_d, cq_oe_q, cq_oe_d, hz_q, hz_d;

  always_comb begin
    seen_d = tog_s;
    held_d = held_q;
    if (srst) begin
      held_d = '{mode: PAD_SRAM, upd: '0};
    end else if (tog_s != seen_q) begin
      held_d = xfer_q;
    end
  end

  always_comb begin
    pad_d = sram_out;
    dq_oe_d = sram_out_oe;
    cq_oe_d = 1'b1;
    hz_d = 1'b0;
    if (srst) begin
      pad_d = '0;
      dq_oe_d = 1'b0;
      cq_oe_d = 1'b0;
    end else begin
      unique case (held_q.mode)
        PAD_SRAM: ;
        PAD_UPDATE_ALL: begin
          pad_d = held_q.upd;
          dq_oe_d = 1'b1;
        end
        PAD_UPDATE_CQ: begin
          pad_d = held_q.upd;
          dq_oe_d = 1'b0;
          hz_d = 1'b1;
        end
        PAD_HIGHZ: begin
          dq_oe_d = 1'b0;
          cq_oe_d = 1'b0;
          hz_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    seen_q <= seen_d;
    held_q <= held_d;
    pad_q <= pad_d;
    dq_oe_q <= dq_oe_d;
    cq_oe_q <= cq_oe_d;
    hz_q <= hz_d;
  end

  assign pad_out = pad_q;
  assign dq_oe = dq_oe_q;
  assign echo_clock_oe = cq_oe_q;
  assign test_highz = hz_q;

endmodule // scan_instr_logic

// file: bench/scan_instr_logic_properties.sv
// checker of pad steering and test port sequencing
`timescale 1ns/100ps
module scan_instr_checker
  import scan_pkg::*;
(
  // clocks and reset
  input wire logic clock,
  input wire logic srst,
  input wire logic tck,
  // test port
  input wire logic tms,
  input wire logic tdo_oe,
  // memory side and pads
  input wire out_word_t sram_out,
  input wire logic sram_out_oe,
  input wire out_word_t pad_out,
  input wire logic dq_oe,
  input wire logic echo_clock_oe,
  input wire logic test_highz
);
  sequence s_release;
    srst ##1 !srst;
  endsequence
  sequence s_in_shift;
    tdo_oe && !tms;
  endsequence
  sequence s_held_cq;
    (test_highz && echo_clock_oe) [*2];
  endsequence
  reset_pads_a: assert property (@(posedge clock)
    srst |=> pad_out == '0 && !dq_oe && !echo_clock_oe && !test_highz) else $error("pads not reset");
  release_on_a: assert property (@(posedge clock)
    s_release |=> echo_clock_oe && !test_highz) else $error("pads not handed to memory");
  highz_no_drive_a: assert property (@(posedge clock) disable iff (srst)
    test_highz |-> !dq_oe) else $error("data driven while forced off");
  echo_off_a: assert property (@(posedge clock) disable iff (srst)
    !echo_clock_oe && !$past(srst) |-> test_highz && !dq_oe) else $error("partial tristate");
  sram_path_a: assert property (@(posedge clock) disable iff (srst)
    echo_clock_oe && !test_highz && !dq_oe && !$past(srst)
    |-> !$past(sram_out_oe) && pad_out == $past(sram_out)) else $error("memory path wrong");
  extest_hold_a: assert property (@(posedge clock) disable iff (srst)
    s_held_cq ##0 $changed(sram_out)
    |=> !(test_highz && echo_clock_oe) || $stable(pad_out) || pad_out != $past(sram_out))
    else $error("latch drifts");
  tap_exit_a: assert property (@(posedge tck) disable iff (srst)
    tms |=> !tdo_oe) else $error("serial out on after mode high");
  shift_stays_a: assert property (@(posedge tck) disable iff (srst)
    s_in_shift |=> tdo_oe) else $error("shift left early");
endmodule // scan_instr_checker

bind scan_instr_logic scan_instr_checker chk_i (.clock(clock), .srst(srst), .tck(tck),
  .tms(tms), .tdo_oe(tdo_oe), .sram_out(sram_out), .sram_out_oe(sram_out_oe),
  .pad_out(pad_out), .dq_oe(dq_oe), .echo_clock_oe(echo_clock_oe), .test_highz(test_highz));

// file: bench/jtag_ctrl_model.sv
// board test controller model driving the test port
`timescale 1ns/100ps
module jtag_ctrl_model (
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  always #7.5 tck = ~tck;
  // n tck cycles of mode and data bits, serial out taken at each rising edge
  task automatic run(input int n, input logic [63:0] m, input logic [63:0] d,
                     output logic [63:0] r);
    r = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge tck);
      r[i] = tdo;
      tms <= m[i];
      tdi <= d[i];
    end
  endtask
  // instruction load from idle, lsb first; only defined codes are issued
  task automatic ir(input logic [2:0] c);
    logic [63:0] r;
    run(9, 64'h0c3, {c, 4'h0}, r);
  endtask
  // full data scan of 49 bits from idle; capture lands in r[52:4]
  task automatic dr(input logic [48:0] w, output logic [63:0] r);
    run(54, 64'h0018_0000_0000_0001, {w, 3'h0}, r);
  endtask
endmodule // jtag_ctrl_model

// file: bench/scan_instr_logic_bench.sv
// self-checking bench of the boundary-scan instruction logic
`timescale 1ns/100ps
`include "scan_defines.svh"
module scan_instr_logic_bench import scan_pkg::*;;
  localparam logic [31:0] ID = 32'h0000_0001; // arbitrary value
  localparam logic [2:0] CODES [12] = '{`IR_PRELOAD, `IR_EXTEST, `IR_EXTEST, `IR_SAMPLE_Z,
    `IR_EXTEST, `IR_IDREAD, `IR_BYPASS, `IR_PRELOAD, `IR_IDREAD, `IR_BYPASS, `IR_EXTEST,
    `IR_PRELOAD};
  localparam logic [11:0] CTRLS = 12'he25;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, dq_oe, echo_clock_oe, test_highz, ctrl_m;
  logic sram_out_oe = 1'b0;
  logic sram_read = 1'b0;
  logic [27:0] misc_pad_in = '0;
  out_word_t sram_out = '0;
  out_word_t pad_in = '0;
  out_word_t pad_out, latch_m;
  logic [31:0] seed = 32'hde31fab1;
  logic [63:0] junk;
  int errors = 0;
  int n_checks = 0;
  always #50 clock = ~clock;
  scan_instr_logic #(.ID_VALUE(ID)) uut (.clock(clock), .srst(srst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .sram_out(sram_out), .sram_out_oe(sram_out_oe),
    .sram_read(sram_read), .pad_in(pad_in), .misc_pad_in(misc_pad_in), .pad_out(pad_out),
    .dq_oe(dq_oe), .echo_clock_oe(echo_clock_oe), .test_highz(test_highz));
  jtag_ctrl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected scan-out after a capture under code c
  function automatic logic [48:0] exp_cap(input logic [2:0] c, input logic [48:0] w);
    out_word_t s;
    s = pad_in;
    if (c == `IR_PRELOAD) s = '{sram_out.cq, sram_out.cq_n, sram_read ? sram_out.dq : pad_in.dq};
    if (c == `IR_IDREAD) return {w[16:0], ID};
    if (c == `IR_BYPASS) return {w[47:0], 1'b0};
    return {ctrl_m, misc_pad_in, s.cq_n, s.cq, s.dq};
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // pad drive once the hand-over has settled
  task automatic pads(input logic [2:0] c);
    out_word_t p;
    logic [2:0] f;
    repeat (6) @(negedge clock);
    p = sram_out;
    f = {sram_out_oe, 2'h2};
    if (c == `IR_EXTEST) begin
      p = latch_m;
      f = {ctrl_m, 1'b1, !ctrl_m};
    end
    if (c == `IR_SAMPLE_Z) begin
      p = '0;
      f = 3'h1;
    end
    chk({c == `IR_SAMPLE_Z ? 20'h0 : pad_out, dq_oe, echo_clock_oe, test_highz}, {p, f}, "pads");
  endtask
  task automatic step(input logic [2:0] c, input logic k);
    logic [63:0] a, b;
    logic [48:0] w;
    a = {xs(), xs()};
    b = {xs(), xs()};
    w = {k, b[47:0]};
    @(posedge clock);
    sram_out <= a[19:0];
    pad_in <= a[39:20];
    misc_pad_in <= a[59:32];
    sram_out_oe <= a[60];
    sram_read <= a[61];
    ctl.ir(c);
    pads(c);
    ctl.dr(w, b);
    chk(b[52:4], exp_cap(c, w), "capture");
    if (c == `IR_EXTEST || c == `IR_PRELOAD) begin
      ctrl_m = k;
      latch_m = '{w[18], w[19], w[17:0]};
    end
    pads(c);
    $display("step code %0d done", c);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    for (int p = 0; p < 2; p++) begin
      @(posedge clock);
      srst <= 1'b1;
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      ctrl_m = 1'b0;
      latch_m = '0;
      repeat (3) @(posedge clock);
      ctl.run(1, 64'h0, 64'h0, junk);
      ctl.dr(49'h0, junk);
      chk(junk[35:4], ID, "default id");
      pads(`IR_IDREAD);
      $display("reset pass %0d done", p);
      for (int i = 0; i < 12; i++) begin
        step(CODES[i], CTRLS[i]);
      end
    end
    tally_and_finish();
  end
  initial begin
    // about four times the expected run
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule // scan_instr_logic_bench
